// ### hdl/tec_top.sv
// apb-controlled external count inputs for two timers
//
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module tec_top #(
  parameter int CNT_W   = tec_pkg::CNT_W,
  parameter int INT_DIV = tec_pkg::INT_DIV
) (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        port_one_bit_four_i,
  output logic             port_one_bit_four_o,
  output logic             port_one_bit_four_oe_o,
  input  wire logic        port_one_bit_five_i,
  output logic             port_one_bit_five_o,
  output logic             port_one_bit_five_oe_o,
  input  wire logic        port_one_bit_six_i,
  output logic             port_one_bit_six_o,
  output logic             port_one_bit_six_oe_o,
  input  wire logic        port_one_bit_seven_i,
  output logic             port_one_bit_seven_o,
  output logic             port_one_bit_seven_oe_o,
  output logic             baud_ext_sel_o,
  output logic             baud_tick_o
);

  initial begin
    if (CNT_W < 2 || CNT_W > 32) $error("counter width out of range");
    if (INT_DIV < 1 || INT_DIV > 256) $error("internal divider out of range");
  end

  localparam int          NP    = tec_pkg::NUM_PINS;
  localparam int          BB    = tec_pkg::CTL_B_BASE;
  localparam logic [7:0]  DIV_M = 8'(INT_DIV - 1);

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [31:0]      ctrl_ff;
  logic [NP-1:0]    pinsel_ff;
  logic [NP-1:0]    port_out_ff;
  logic [NP-1:0]    port_oe_ff;
  logic [31:0]      prdata_ff;
  logic [7:0]       div_ff;
  logic             tick_ff;
  logic             baud_tick_ff;
  logic             a_clk_q_ff;
  logic [NP-1:0]    pin_raw;
  logic [NP-1:0]    pin_sync;
  logic [CNT_W-1:0] cnt_a;
  logic [CNT_W-1:0] cnt_b;

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  wire        setup    = psel_i & !penable_i;
  wire        access   = psel_i & penable_i;
  wire        wr_en    = access & pwrite_i;
  wire        hit_ctrl = paddr_i == tec_pkg::OFS_CTRL;
  wire        hit_sel  = paddr_i == tec_pkg::OFS_PINSEL;
  wire        hit_out  = paddr_i == tec_pkg::OFS_PORT_OUT;
  wire        hit_oe   = paddr_i == tec_pkg::OFS_PORT_OE;
  wire        hit_in   = paddr_i == tec_pkg::OFS_PORT_IN;
  wire        hit_a    = paddr_i == tec_pkg::OFS_CNT_A;
  wire        hit_b    = paddr_i == tec_pkg::OFS_CNT_B;
  wire        mapped   = hit_ctrl | hit_sel | hit_out | hit_oe | hit_in | hit_a | hit_b;
  // port input is read-only; a write there is refused
  wire        bad      = !mapped | (pwrite_i & hit_in);
  wire        wr_ok    = wr_en & !bad;
  wire        load_a   = wr_ok & hit_a;
  wire        load_b   = wr_ok & hit_b;
  wire [31:0] cnt_a_w  = 32'(cnt_a);
  wire [31:0] cnt_b_w  = 32'(cnt_b);
  wire [31:0] rd_mux   = hit_ctrl ? ctrl_ff :
                         hit_sel  ? 32'(pinsel_ff) :
                         hit_out  ? 32'(port_out_ff) :
                         hit_oe   ? 32'(port_oe_ff) :
                         hit_in   ? 32'(pin_sync) :
                         hit_a    ? cnt_a_w :
                         hit_b    ? cnt_b_w : 32'h0000_0000;

  assign pready_o  = 1'b1;
  assign pslverr_o = access & bad;
  assign prdata_o  = prdata_ff;

  // read data captured in setup, so it stands through the access phase
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prdata_ff <= 32'h0000_0000;
    end else if (setup) begin
      prdata_ff <= pwrite_i ? 32'h0000_0000 : rd_mux;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_ff     <= tec_pkg::CTRL_RST;
      pinsel_ff   <= tec_pkg::PINSEL_RST;
      port_out_ff <= tec_pkg::PORT_RST;
      port_oe_ff  <= tec_pkg::PORT_RST;
    end else if (wr_ok) begin
      if (hit_ctrl) ctrl_ff     <= pwdata_i;
      if (hit_sel)  pinsel_ff   <= pwdata_i[NP-1:0];
      if (hit_out)  port_out_ff <= pwdata_i[NP-1:0];
      if (hit_oe)   port_oe_ff  <= pwdata_i[NP-1:0];
    end
  end

  // ---------------------------------------------------------------
  // shared pins
  // ---------------------------------------------------------------
  assign pin_raw = {port_one_bit_seven_i, port_one_bit_six_i,
                    port_one_bit_five_i, port_one_bit_four_i};

  tec_sync #(
    .W (NP)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .d_i     (pin_raw),
    .q_o     (pin_sync)
  );

  // a pin given to the timer is never driven by the port
  wire [NP-1:0] oe_eff = port_oe_ff & ~pinsel_ff;

  assign port_one_bit_four_o     = port_out_ff[tec_pkg::PIN_A_CLK];
  assign port_one_bit_four_oe_o  = oe_eff[tec_pkg::PIN_A_CLK];
  assign port_one_bit_five_o     = port_out_ff[tec_pkg::PIN_A_DIR];
  assign port_one_bit_five_oe_o  = oe_eff[tec_pkg::PIN_A_DIR];
  assign port_one_bit_six_o      = port_out_ff[tec_pkg::PIN_B_CLK];
  assign port_one_bit_six_oe_o   = oe_eff[tec_pkg::PIN_B_CLK];
  assign port_one_bit_seven_o    = port_out_ff[tec_pkg::PIN_B_DIR];
  assign port_one_bit_seven_oe_o = oe_eff[tec_pkg::PIN_B_DIR];

  // ---------------------------------------------------------------
  // internal count rate
  // ---------------------------------------------------------------
  wire       div_end = div_ff == DIV_M;
  wire [7:0] nxt_div = div_end ? 8'h00 : div_ff + 8'h01;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_ff  <= 8'h00;
      tick_ff <= 1'b0;
    end else begin
      div_ff  <= nxt_div;
      tick_ff <= div_end;
    end
  end

  // ---------------------------------------------------------------
  // timer channels; external pins only count while selected
  // ---------------------------------------------------------------
  wire a_clk_ok = pinsel_ff[tec_pkg::PIN_A_CLK];
  wire a_dir_ok = pinsel_ff[tec_pkg::PIN_A_DIR];
  wire b_clk_ok = pinsel_ff[tec_pkg::PIN_B_CLK];
  wire b_dir_ok = pinsel_ff[tec_pkg::PIN_B_DIR];
  wire a_quad   = ctrl_ff[tec_pkg::CTL_QUAD];
  wire b_quad   = ctrl_ff[BB + tec_pkg::CTL_QUAD];
  wire a_ext    = ctrl_ff[tec_pkg::CTL_EXT_CLK];
  wire b_ext    = ctrl_ff[BB + tec_pkg::CTL_EXT_CLK];
  // quadrature needs both pins in timer use
  wire a_en     = ctrl_ff[tec_pkg::CTL_EN] &
                  (a_quad ? a_clk_ok & a_dir_ok : !a_ext | a_clk_ok);
  wire b_en     = ctrl_ff[BB + tec_pkg::CTL_EN] &
                  (b_quad ? b_clk_ok & b_dir_ok : !b_ext | b_clk_ok);
  wire a_xdir   = ctrl_ff[tec_pkg::CTL_EXT_DIR] & a_dir_ok;
  wire b_xdir   = ctrl_ff[BB + tec_pkg::CTL_EXT_DIR] & b_dir_ok;

  tec_chan #(
    .W (CNT_W)
  ) u_chan_a (
    .clk_i      (clk_i),
    .rst_n_i    (rst_n_i),
    .en_i       (a_en),
    .ext_clk_i  (a_ext),
    .ext_dir_i  (a_xdir),
    .sw_dir_i   (ctrl_ff[tec_pkg::CTL_SW_DIR]),
    .quad_i     (a_quad),
    .int_tick_i (tick_ff),
    .clk_pin_i  (pin_sync[tec_pkg::PIN_A_CLK]),
    .dir_pin_i  (pin_sync[tec_pkg::PIN_A_DIR]),
    .load_i     (load_a),
    .load_val_i (pwdata_i[CNT_W-1:0]),
    .count_o    (cnt_a)
  );

  tec_chan #(
    .W (CNT_W)
  ) u_chan_b (
    .clk_i      (clk_i),
    .rst_n_i    (rst_n_i),
    .en_i       (b_en),
    .ext_clk_i  (b_ext),
    .ext_dir_i  (b_xdir),
    .sw_dir_i   (ctrl_ff[BB + tec_pkg::CTL_SW_DIR]),
    .quad_i     (b_quad),
    .int_tick_i (tick_ff),
    .clk_pin_i  (pin_sync[tec_pkg::PIN_B_CLK]),
    .dir_pin_i  (pin_sync[tec_pkg::PIN_B_DIR]),
    .load_i     (load_b),
    .load_val_i (pwdata_i[CNT_W-1:0]),
    .count_o    (cnt_b)
  );

  // ---------------------------------------------------------------
  // baud source
  // ---------------------------------------------------------------
  // internal source ticks every cycle; the baud divider lives elsewhere
  wire baud_ext  = ctrl_ff[tec_pkg::CTL_BAUD_EXT] & a_clk_ok;
  wire a_rise    = pin_sync[tec_pkg::PIN_A_CLK] & !a_clk_q_ff;
  wire nxt_baud  = baud_ext ? a_rise : 1'b1;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      a_clk_q_ff   <= 1'b0;
      baud_tick_ff <= 1'b0;
    end else begin
      a_clk_q_ff   <= pin_sync[tec_pkg::PIN_A_CLK];
      baud_tick_ff <= nxt_baud;
    end
  end

  assign baud_ext_sel_o = baud_ext;
  assign baud_tick_o    = baud_tick_ff;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  baud_ext_tick_a: assert property (baud_ext && a_rise ##1 baud_ext
    |-> baud_tick_o) else $error("baud tick missing on pin rise");
  baud_ext_idle_a: assert property (baud_ext && !a_rise
    |=> !baud_tick_o) else $error("baud tick without pin rise");
  pin_release_a: assert property (wr_ok && hit_sel && pwdata_i[0]
    |=> !port_one_bit_four_oe_o) else $error("timer pin still driven");
  quad_gate_a: assert property (a_quad && !(a_clk_ok && a_dir_ok) && !load_a
    |=> $stable(cnt_a)) else $error("quadrature runs without both pins");
  quad_gate_b_a: assert property (b_quad && !(b_clk_ok && b_dir_ok) && !load_b
    |=> $stable(cnt_b)) else $error("quadrature runs without both pins");
  a_unsel_hold_a: assert property (a_ext && !a_quad && !a_clk_ok && !load_a
    |=> $stable(cnt_a)) else $error("timer a counted a port pin");
  b_unsel_hold_a: assert property (b_ext && !b_quad && !b_clk_ok && !load_b
    |=> $stable(cnt_b)) else $error("timer b counted a port pin");
  a_int_hold_a: assert property (!a_quad && !a_ext && !tick_ff && !load_a
    |=> $stable(cnt_a)) else $error("timer a stepped off its pin while internal");
  b_int_hold_a: assert property (!b_quad && !b_ext && !tick_ff && !load_b
    |=> $stable(cnt_b)) else $error("timer b stepped off its pin while internal");

  wire [NP-1:0] oe_pins = {port_one_bit_seven_oe_o, port_one_bit_six_oe_o,
                           port_one_bit_five_oe_o, port_one_bit_four_oe_o};

  pin_give_a: assert property (wr_ok && hit_sel
    |=> (oe_pins & $past(pwdata_i[NP-1:0])) == 4'h0) else $error("timer pin still driven");
  port_in_ro_a: assert property (wr_en && hit_in
    |=> $stable(port_out_ff) && $stable(port_oe_ff) && $stable(pinsel_ff)) else $error("port input write landed");
  baud_int_a: assert property (!baud_ext
    |=> baud_tick_o) else $error("internal baud tick missing");
  baud_pulse_a: assert property (baud_ext ##1 baud_ext && baud_tick_o
    |=> !baud_tick_o) else $error("baud tick wider than one cycle");

  baud_ext_c: cover property (baud_ext && a_rise ##1 baud_tick_o);
  cnt_load_c: cover property (load_a ##1 b_quad);
  unsel_edge_c: cover property (a_ext && !a_clk_ok && a_rise);

  // ---------------------------------------------------------------
  // check helpers
  // ---------------------------------------------------------------
  // cycles since the last internal tick; a counter, not a long repetition
  logic [8:0] gap_ff;
  logic       gap_seen_ff;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gap_ff      <= 9'h000;
      gap_seen_ff <= 1'b0;
    end else if (tick_ff) begin
      gap_ff      <= 9'h000;
      gap_seen_ff <= 1'b1;
    end else begin
      gap_ff      <= gap_ff + 9'h001;
    end
  end

  tick_rate_a: assert property (tick_ff && gap_seen_ff
    |-> gap_ff == 9'(INT_DIV - 1)) else $error("internal count rate wrong");

endmodule

// ### hdl/tec_pkg.sv
// constants for the timer external count input block
//
// How it works
// - timer a steps on both edges of its external clock pin
// - timer b steps on both edges of its external clock pin
// - timer a counts up while its direction pin is high, down while low
// - timer b counts up while its direction pin is high, down while low
// - timer a quadrature mode takes phases from its clock and direction pins
// - timer b quadrature mode takes phases from its clock and direction pins
// - baud generator may take its clock from timer a clock pin
// - each of four shared port pins is switchable between port and timer use
package tec_pkg;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_PINSEL   = 8'h04;
  localparam logic [7:0] OFS_PORT_OUT = 8'h08;
  localparam logic [7:0] OFS_PORT_OE  = 8'h0C;
  localparam logic [7:0] OFS_PORT_IN  = 8'h10;
  localparam logic [7:0] OFS_CNT_A    = 8'h14;
  localparam logic [7:0] OFS_CNT_B    = 8'h18;

  // ---------------------------------------------------------------
  // control fields; timer b fields sit at CTL_B_BASE above timer a
  // ---------------------------------------------------------------
  localparam int CTL_EN       = 0;
  localparam int CTL_EXT_CLK  = 1;
  localparam int CTL_EXT_DIR  = 2;
  localparam int CTL_SW_DIR   = 3;
  localparam int CTL_QUAD     = 4;
  localparam int CTL_B_BASE   = 8;
  localparam int CTL_BAUD_EXT = 16;

  // pin select / port bit positions
  localparam int PIN_A_CLK = 0;
  localparam int PIN_A_DIR = 1;
  localparam int PIN_B_CLK = 2;
  localparam int PIN_B_DIR = 3;
  localparam int NUM_PINS  = 4;

  // ---------------------------------------------------------------
  // reset values and defaults
  // ---------------------------------------------------------------
  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
  localparam logic [3:0]  PINSEL_RST = 4'h0;
  localparam logic [3:0]  PORT_RST   = 4'h0;
  localparam int          CNT_W      = 16;
  localparam int          INT_DIV    = 4;

endpackage

// ### hdl/tec_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module tec_sync #(
  parameter int W = 4
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // first stage feeds only the second
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= d_i;
      sync_ff <= meta_ff;
    end
  end

  assign q_o = sync_ff;

endmodule

// ### hdl/tec_chan.sv
// one up/down counter channel with edge and quadrature decode
`timescale 1ns/1ps
module tec_chan #(
  parameter int W = 16
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         en_i,
  input  wire logic         ext_clk_i,
  input  wire logic         ext_dir_i,
  input  wire logic         sw_dir_i,
  input  wire logic         quad_i,
  input  wire logic         int_tick_i,
  input  wire logic         clk_pin_i,
  input  wire logic         dir_pin_i,
  input  wire logic         load_i,
  input  wire logic [W-1:0] load_val_i,
  output logic      [W-1:0] count_o
);

  localparam logic [W-1:0] ONE = W'(1);

  initial begin
    if (W < 2 || W > 32) $error("tec_chan width out of range");
  end

  logic         clk_q_ff;
  logic         dir_q_ff;
  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire clk_edge  = clk_pin_i ^ clk_q_ff;
  wire dir_edge  = dir_pin_i ^ dir_q_ff;
  // both phases moving at once is illegal; it is dropped
  wire quad_step = clk_edge ^ dir_edge;
  wire quad_up   = clk_pin_i ^ dir_q_ff;
  wire lin_step  = ext_clk_i ? clk_edge : int_tick_i;
  wire lin_up    = ext_dir_i ? dir_pin_i : sw_dir_i;
  wire step      = en_i & (quad_i ? quad_step : lin_step);
  wire up        = quad_i ? quad_up : lin_up;

  // software load wins over a step in the same cycle
  assign nxt_cnt = load_i ? load_val_i :
                   !step  ? cnt_ff :
                   up     ? cnt_ff + ONE : cnt_ff - ONE;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clk_q_ff <= 1'b0;
      dir_q_ff <= 1'b0;
      cnt_ff   <= '0;
    end else begin
      clk_q_ff <= clk_pin_i;
      dir_q_ff <= dir_pin_i;
      cnt_ff   <= nxt_cnt;
    end
  end

  assign count_o = cnt_ff;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  wire lin_ext = en_i & !quad_i & ext_clk_i & !load_i;
  wire quad_on = en_i & quad_i & !load_i;

  ext_edge_up_a: assert property (lin_ext && clk_edge && lin_up && ext_dir_i && dir_pin_i
    |=> cnt_ff == $past(cnt_ff) + ONE) else $error("no up step on clock edge");
  ext_edge_dn_a: assert property (lin_ext && clk_edge && ext_dir_i && !dir_pin_i
    |=> cnt_ff == $past(cnt_ff) - ONE) else $error("no down step on clock edge");
  no_edge_hold_a: assert property (lin_ext && !clk_edge
    |=> cnt_ff == $past(cnt_ff)) else $error("count moved without edge");
  quad_phase_b_a: assert property (quad_on && dir_edge && !clk_edge
    |=> cnt_ff != $past(cnt_ff)) else $error("direction phase edge not counted");
  quad_fwd_a: assert property (quad_on && quad_step && quad_up
    |=> cnt_ff == $past(cnt_ff) + ONE) else $error("quadrature forward wrong");
  quad_rev_a: assert property (quad_on && quad_step && !quad_up
    |=> cnt_ff == $past(cnt_ff) - ONE) else $error("quadrature reverse wrong");

  quad_rev_c: cover property (quad_on && quad_step && !quad_up);
  ext_dn_c:   cover property (lin_ext && clk_edge && !lin_up);

endmodule

// ### tb/tec_src.sv
// far-side model: count source and quadrature encoder on the four timer pins
`timescale 1ns/1ps
module tec_src #(
  parameter int GAP = 4
) (
  input  wire logic       clk_i,
  output logic      [3:0] pins_o
);
  // ---------------------------------------------------------------
  // pin drive
  // ---------------------------------------------------------------
  // gap keeps edges wider than the pin synchroniser can miss
  initial pins_o = 4'h0;

  task automatic set(input int k, input logic v);
    @(posedge clk_i);
    pins_o[k] <= v;
    repeat (GAP) @(posedge clk_i);
  endtask

  task automatic steps(input int k, input int n);
    repeat (n) begin
      @(posedge clk_i);
      pins_o[k] <= ~pins_o[k];
      repeat (GAP) @(posedge clk_i);
    end
  endtask

  // phase index from current levels, so a reversal starts where it stands
  task automatic quad(input int t, input logic up, input int n);
    logic [1:0] ph;
    ph = {pins_o[2 * t + 1], pins_o[2 * t] ^ pins_o[2 * t + 1]};
    repeat (n) begin
      ph = up ? ph + 2'd1 : ph - 2'd1;
      @(posedge clk_i);
      pins_o[2 * t]     <= ph[1] ^ ph[0];
      pins_o[2 * t + 1] <= ph[1];
      repeat (GAP) @(posedge clk_i);
    end
  endtask
endmodule

// ### tb/timer_external_count_inputs_tb.sv
// self-checking testbench for the timer external count inputs
`timescale 1ns/1ps
module timer_external_count_inputs_tb;
  logic        clk_i       = 1'b0;
  logic        rst_n_i     = 1'b0;
  logic        psel        = 1'b0;
  logic        penable     = 1'b0;
  logic        pwrite      = 1'b0;
  logic [7:0]  paddr       = 8'h00;
  logic [31:0] pwdata      = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [3:0]  pin_o;
  logic [3:0]  pin_oe;
  logic [3:0]  src;
  logic [3:0]  lvl;
  logic        baud_sel;
  logic        baud_tick;
  logic [32:0] exp_q[$];
  int          n_fail      = 0;
  int          checks_done = 0;
  int          cyc         = 0;
  int          n_tick      = 0;
  int          seed        = 25;

  always #2 clk_i = ~clk_i;
  // port drive wins over the far side while enabled
  assign lvl = (pin_oe & pin_o) | (~pin_oe & src);

  tec_src i_src (.clk_i(clk_i), .pins_o(src));

  tec_top #(.CNT_W(16), .INT_DIV(4)) i_dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .port_one_bit_four_i(lvl[0]), .port_one_bit_four_o(pin_o[0]), .port_one_bit_four_oe_o(pin_oe[0]),
    .port_one_bit_five_i(lvl[1]), .port_one_bit_five_o(pin_o[1]), .port_one_bit_five_oe_o(pin_oe[1]),
    .port_one_bit_six_i(lvl[2]), .port_one_bit_six_o(pin_o[2]), .port_one_bit_six_oe_o(pin_oe[2]),
    .port_one_bit_seven_i(lvl[3]), .port_one_bit_seven_o(pin_o[3]), .port_one_bit_seven_oe_o(pin_oe[3]),
    .baud_ext_sel_o(baud_sel), .baud_tick_o(baud_tick)
  );

  // ---------------------------------------------------------------
  // compare, bus and closing tasks
  // ---------------------------------------------------------------
  task automatic cmp_bus(input logic [32:0] e, input logic [32:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch bus at %0t exp %h got %h", $time, e, g);
    end
  endtask

  task automatic cmp_pin(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch pin at %0t exp %h got %h", $time, e, g);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // expected {pslverr, prdata} noted before the transfer starts
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
    exp_q.push_back(e);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    @(posedge clk_i);
    while (pready !== 1'b1) @(posedge clk_i);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic err);
    apb(1'b1, a, d, {err, 32'h0000_0000});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d);
    apb(1'b0, a, 32'h0000_0000, {1'b0, d});
  endtask

  // ---------------------------------------------------------------
  // monitor and timeout
  // ---------------------------------------------------------------
  always @(posedge clk_i) begin
    cyc++;
    if (baud_tick === 1'b1) n_tick++;
    if (psel && penable && pready === 1'b1) cmp_bus(exp_q.pop_front(), {pslverr, prdata});
    if (cyc == 20000) begin
      n_fail++;
      end_sim();
    end
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin : main
    logic [3:0] v;
    logic [7:0] ca;
    int         n1;
    int         n2;
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    for (int k = 0; k < 7; k++) begin
      rd(8'(4 * k), 32'h0000_0000);
    end
    apb(1'b0, 8'h1C, 32'h0000_0000, 33'h1_0000_0000);
    wr(tec_pkg::OFS_PORT_IN, 32'h0000_000F, 1'b1);
    v = 4'($random(seed));
    wr(tec_pkg::OFS_PORT_OUT, {28'h000_0000, v}, 1'b0);
    wr(tec_pkg::OFS_PORT_OE, 32'h0000_000F, 1'b0);
    cmp_pin({pin_oe, pin_o}, {4'hF, v});
    wr(tec_pkg::OFS_PINSEL, 32'h0000_0005, 1'b0);
    cmp_pin({pin_oe, pin_o}, {4'hA, v});
    repeat (3) @(posedge clk_i);
    rd(tec_pkg::OFS_PORT_IN, {28'h000_0000, v & 4'hA});
    wr(tec_pkg::OFS_PORT_OE, 32'h0000_0000, 1'b0);
    wr(tec_pkg::OFS_PINSEL, 32'h0000_000F, 1'b0);
    // both edges counted, direction pin alone never steps
    for (int t = 0; t < 2; t++) begin
      ca = t ? tec_pkg::OFS_CNT_B : tec_pkg::OFS_CNT_A;
      n1 = $random(seed) & 3;
      wr(tec_pkg::OFS_CTRL, 32'h0000_0007 << (8 * t), 1'b0);
      i_src.set(2 * t + 1, 1'b1);
      i_src.steps(2 * t, n1);
      i_src.set(2 * t + 1, 1'b0);
      i_src.steps(2 * t, 2);
      rd(ca, {16'h0000, 16'(n1 - 2)});
    end
    // quadrature with a reversal mid-run
    for (int t = 0; t < 2; t++) begin
      ca = t ? tec_pkg::OFS_CNT_B : tec_pkg::OFS_CNT_A;
      n1 = 1 + ($random(seed) & 7);
      n2 = 1 + ($random(seed) & 7);
      wr(tec_pkg::OFS_CTRL, 32'h0000_0011 << (8 * t), 1'b0);
      wr(ca, 32'h0000_0000, 1'b0);
      i_src.quad(t, 1'b1, n1);
      i_src.quad(t, 1'b0, n2);
      rd(ca, {16'h0000, 16'(n1 - n2)});
    end
    // baud source and pin select gating
    i_src.set(0, 1'b0);
    wr(tec_pkg::OFS_CNT_A, 32'h0000_0000, 1'b0);
    // pin released first, so the baud source does not see it selected until pin select is written back to 0xF
    wr(tec_pkg::OFS_PINSEL, 32'h0000_000E, 1'b0);
    wr(tec_pkg::OFS_CTRL, 32'h0001_0003, 1'b0);
    cmp_pin({6'h00, baud_sel, baud_tick}, 8'h01);
    i_src.steps(0, 2);
    wr(tec_pkg::OFS_PINSEL, 32'h0000_000F, 1'b0);
    @(posedge clk_i);
    cmp_pin({6'h00, baud_sel, baud_tick}, 8'h02);
    n1 = n_tick;
    i_src.steps(0, 6);
    cmp_pin(8'(n_tick - n1), 8'h03);
    rd(tec_pkg::OFS_CNT_A, 32'h0000_FFFA);
    // internal source, software up: enable and disable land 40 edges apart, one tick in four
    wr(tec_pkg::OFS_CNT_A, 32'h0000_0000, 1'b0);
    wr(tec_pkg::OFS_CTRL, 32'h0000_0009, 1'b0);
    repeat (37) @(posedge clk_i);
    wr(tec_pkg::OFS_CTRL, 32'h0000_0000, 1'b0);
    rd(tec_pkg::OFS_CNT_A, 32'h0000_000A);
    repeat (2) @(posedge clk_i);
    if (exp_q.size() != 0) n_fail++;
    end_sim();
  end
endmodule
